// file: rtl/hso_pkg.sv
package hso_pkg;

  // clock and out-of-band timing, times in picoseconds
  localparam int CLK_PERIOD_PS    = 8000;
  localparam int BURST_PS         = 106700;
  localparam int INIT_GAP_PS      = 320000;
  localparam int WAKE_GAP_PS      = 106700;
  localparam int WAKE_OFF_MAX_PS  = 175000;
  localparam int WAKE_GAP_MIN_PS  = 35000;
  localparam int INIT_GAP_MIN_PS  = 240000;
  localparam int INIT_GAP_MAX_PS  = 400000;

  // least and nominal times and the wake hold round up, longest limits round down
  localparam logic [7:0] BURST_CYC        = 8'((BURST_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] INIT_GAP_CYC     = 8'((INIT_GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] WAKE_GAP_CYC     = 8'((WAKE_GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] WAKE_HOLD_CYC    = 8'((WAKE_OFF_MAX_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] WAKE_OFF_MAX_CYC = 8'(WAKE_OFF_MAX_PS / CLK_PERIOD_PS);
  localparam logic [7:0] WAKE_GAP_MIN_CYC = 8'((WAKE_GAP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] INIT_GAP_MIN_CYC = 8'((INIT_GAP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] INIT_GAP_MAX_CYC = 8'(INIT_GAP_MAX_PS / CLK_PERIOD_PS);

  localparam logic [3:0] RESET_BURSTS = 4'h6;
  localparam logic [3:0] WAKE_BURSTS  = 4'h6;
  localparam int         DET_GAPS     = 3;

  // register map
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_STATUS   = 4'h4;
  localparam logic [3:0] REG_IRQ_STAT = 4'h8;
  localparam logic [3:0] REG_IRQ_MASK = 4'hC;

  localparam int         CTRL_CAL_EN   = 0;
  localparam int         CTRL_PWR_DOWN = 1;
  localparam logic [1:0] CTRL_RESET    = 2'h0;

  localparam int         IRQ_INIT  = 0;
  localparam int         IRQ_WAKE  = 1;
  localparam int         IRQ_ALIGN = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  typedef enum logic [3:0] {
    host_reset_state,
    host_wait_init_state,
    host_wait_init_release_state,
    host_calibration_state,
    host_send_wake_state,
    host_wait_wake_state,
    host_wait_wake_release_state,
    host_wait_align_state,
    host_power_down_state
  } hso_state_t;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_BURST,
    TX_GAP,
    TX_HOLD
  } hso_tx_t;

endpackage : hso_pkg

// file: rtl/hso_oob_host.sv
// Implementation choices: strobed register access and the placing of the registers.
module hso_oob_host #(
  parameter int DET_GAPS = hso_pkg::DET_GAPS
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hostResetReq,
  input  wire logic        rxIdle,
  input  wire logic        calDone,
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdData,
  output logic             txAlignBurst,
  output logic             calStart,
  output logic             phyWaitAlign,
  output logic             irq
);

  hso_pkg::hso_state_t state;
  hso_pkg::hso_state_t next_state;
  hso_pkg::hso_tx_t    txPhase;
  logic                fsmRst_n;
  logic [7:0]          txCnt;
  logic [3:0]          burstsLeft;
  logic                txWake;
  logic                txDone;
  logic                resetStart;
  logic                wakeStart;
  logic                wakeIssued;
  logic                prevIdle;
  logic [7:0]          idleCnt;
  logic                gapEnd;
  logic                wakeGap;
  logic                initGap;
  logic [2:0]          wakeRun;
  logic [2:0]          initRun;
  logic                comWakeDet;
  logic                comInitDet;
  logic                prevWakeDet;
  logic                prevInitDet;
  logic [1:0]          ctrl;
  logic [2:0]          irqStat;
  logic [2:0]          irqMask;
  logic [2:0]          irqEvt;
  logic                wakeFromDevice;

  // adapter reset shares the asynchronous path so the fsm drops at once
  assign fsmRst_n = rst_n & ~hostResetReq;

  always_ff @(posedge clk or negedge fsmRst_n) begin
    if (!fsmRst_n) begin
      state <= hso_pkg::host_reset_state;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      hso_pkg::host_reset_state: begin
        next_state = hso_pkg::host_wait_init_state;
      end
      hso_pkg::host_wait_init_state: begin
        if (comInitDet) begin
          next_state = hso_pkg::host_wait_init_release_state;
        end
      end
      hso_pkg::host_wait_init_release_state: begin
        if (!comInitDet) begin
          next_state = hso_pkg::host_calibration_state;
        end
      end
      hso_pkg::host_calibration_state: begin
        if (!ctrl[hso_pkg::CTRL_CAL_EN] || calDone) begin
          next_state = hso_pkg::host_send_wake_state;
        end
      end
      hso_pkg::host_send_wake_state: begin
        if (txDone && txWake) begin
          next_state = comWakeDet ? hso_pkg::host_wait_wake_release_state
                                  : hso_pkg::host_wait_wake_state;
        end
      end
      hso_pkg::host_wait_wake_state: begin
        if (comWakeDet) begin
          next_state = hso_pkg::host_wait_wake_release_state;
        end
      end
      hso_pkg::host_wait_wake_release_state: begin
        if (!comWakeDet) begin
          next_state = hso_pkg::host_wait_align_state;
        end
      end
      hso_pkg::host_wait_align_state: begin
        if (ctrl[hso_pkg::CTRL_PWR_DOWN]) begin
          next_state = hso_pkg::host_power_down_state;
        end
      end
      hso_pkg::host_power_down_state: begin
        if (comWakeDet) begin
          next_state = hso_pkg::host_wait_wake_release_state;
        end else if (!ctrl[hso_pkg::CTRL_PWR_DOWN]) begin
          next_state = hso_pkg::host_send_wake_state;
        end
      end
    endcase
    // cominit overrides every state except reset itself
    if (comInitDet && state != hso_pkg::host_reset_state) begin
      next_state = hso_pkg::host_wait_init_release_state;
    end
  end

  // comreset goes out on departure from reset; comwake waits for an idle sender
  assign resetStart = (state == hso_pkg::host_reset_state);
  assign wakeStart  = (state == hso_pkg::host_send_wake_state) && !wakeIssued &&
                      (txPhase == hso_pkg::TX_IDLE) && !resetStart;

  always_ff @(posedge clk or negedge fsmRst_n) begin
    if (!fsmRst_n) begin
      wakeIssued <= 1'b0;
    end else if (state != hso_pkg::host_send_wake_state) begin
      wakeIssued <= 1'b0;
    end else if (wakeStart) begin
      wakeIssued <= 1'b1;
    end
  end

  // burst generator; calibration never drives it, so no oob-like pattern appears
  always_ff @(posedge clk or negedge fsmRst_n) begin
    if (!fsmRst_n) begin
      txPhase      <= hso_pkg::TX_IDLE;
      txCnt        <= 8'h00;
      burstsLeft   <= 4'h0;
      txWake       <= 1'b0;
      txDone       <= 1'b0;
      txAlignBurst <= 1'b0;
    end else begin
      txDone <= 1'b0;
      if (resetStart || wakeStart) begin
        txPhase      <= hso_pkg::TX_BURST;
        txCnt        <= 8'h00;
        burstsLeft   <= resetStart ? hso_pkg::RESET_BURSTS : hso_pkg::WAKE_BURSTS;
        txWake       <= wakeStart;
        txAlignBurst <= 1'b1;
      end else begin
        unique case (txPhase)
          hso_pkg::TX_IDLE: begin
            txCnt <= 8'h00;
          end
          hso_pkg::TX_BURST: begin
            if (txCnt == hso_pkg::BURST_CYC - 8'h01) begin
              txCnt        <= 8'h00;
              burstsLeft   <= burstsLeft - 4'h1;
              txAlignBurst <= 1'b0;
              if (burstsLeft != 4'h1) begin
                txPhase <= hso_pkg::TX_GAP;
              end else if (txWake) begin
                txPhase <= hso_pkg::TX_HOLD;
              end else begin
                txPhase <= hso_pkg::TX_IDLE;
                txDone  <= 1'b1;
              end
            end else begin
              txCnt <= txCnt + 8'h01;
            end
          end
          hso_pkg::TX_GAP: begin
            if (txCnt == (txWake ? hso_pkg::WAKE_GAP_CYC : hso_pkg::INIT_GAP_CYC) - 8'h01) begin
              txCnt        <= 8'h00;
              txPhase      <= hso_pkg::TX_BURST;
              txAlignBurst <= 1'b1;
            end else begin
              txCnt <= txCnt + 8'h01;
            end
          end
          hso_pkg::TX_HOLD: begin
            // far detector must see the spacing run past its off window
            if (txCnt == hso_pkg::WAKE_HOLD_CYC - 8'h01) begin
              txCnt   <= 8'h00;
              txPhase <= hso_pkg::TX_IDLE;
              txDone  <= 1'b1;
            end else begin
              txCnt <= txCnt + 8'h01;
            end
          end
        endcase
      end
    end
  end

  // spacing detector: only idle gaps are timed, bursts may be any length
  assign gapEnd  = prevIdle && !rxIdle;
  assign wakeGap = (idleCnt >= hso_pkg::WAKE_GAP_MIN_CYC) && (idleCnt <= hso_pkg::WAKE_OFF_MAX_CYC);
  assign initGap = (idleCnt >= hso_pkg::INIT_GAP_MIN_CYC) && (idleCnt <= hso_pkg::INIT_GAP_MAX_CYC);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prevIdle <= 1'b1;
      idleCnt  <= 8'h00;
    end else begin
      prevIdle <= rxIdle;
      if (!rxIdle) begin
        idleCnt <= 8'h00;
      end else if (idleCnt != 8'hFF) begin
        idleCnt <= idleCnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wakeRun    <= 3'h0;
      comWakeDet <= 1'b0;
    end else if ((rxIdle && idleCnt > hso_pkg::WAKE_OFF_MAX_CYC) || (gapEnd && !wakeGap)) begin
      wakeRun    <= 3'h0;
      comWakeDet <= 1'b0;
    end else if (gapEnd) begin
      wakeRun <= (wakeRun == 3'h7) ? wakeRun : wakeRun + 3'h1;
      if (wakeRun >= 3'(DET_GAPS - 1)) begin
        comWakeDet <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      initRun    <= 3'h0;
      comInitDet <= 1'b0;
    end else if ((rxIdle && idleCnt > hso_pkg::INIT_GAP_MAX_CYC) || (gapEnd && !initGap)) begin
      initRun    <= 3'h0;
      comInitDet <= 1'b0;
    end else if (gapEnd) begin
      initRun <= (initRun == 3'h7) ? initRun : initRun + 3'h1;
      if (initRun >= 3'(DET_GAPS - 1)) begin
        comInitDet <= 1'b1;
      end
    end
  end

  // wake source memory: device-originated if its comwake arrived while down
  always_ff @(posedge clk or negedge fsmRst_n) begin
    if (!fsmRst_n) begin
      wakeFromDevice <= 1'b0;
    end else if (state == hso_pkg::host_wait_align_state && next_state == hso_pkg::host_power_down_state) begin
      wakeFromDevice <= 1'b0;
    end else if (state == hso_pkg::host_power_down_state && comWakeDet) begin
      wakeFromDevice <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      calStart     <= 1'b0;
      phyWaitAlign <= 1'b0;
    end else begin
      calStart     <= fsmRst_n && (next_state == hso_pkg::host_calibration_state) &&
                      ctrl[hso_pkg::CTRL_CAL_EN];
      phyWaitAlign <= fsmRst_n && (next_state == hso_pkg::host_wait_align_state);
    end
  end

  // register file
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl    <= hso_pkg::CTRL_RESET;
      irqMask <= hso_pkg::IRQ_RESET;
    end else if (regWr) begin
      if (regAddr == hso_pkg::REG_CTRL) begin
        ctrl <= regWrData[1:0];
      end
      if (regAddr == hso_pkg::REG_IRQ_MASK) begin
        irqMask <= regWrData[2:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prevWakeDet <= 1'b0;
      prevInitDet <= 1'b0;
    end else begin
      prevWakeDet <= comWakeDet;
      prevInitDet <= comInitDet;
    end
  end

  assign irqEvt[hso_pkg::IRQ_INIT]  = comInitDet && !prevInitDet;
  assign irqEvt[hso_pkg::IRQ_WAKE]  = comWakeDet && !prevWakeDet;
  assign irqEvt[hso_pkg::IRQ_ALIGN] = fsmRst_n && (next_state == hso_pkg::host_wait_align_state) &&
                                      (state != hso_pkg::host_wait_align_state);

  // an event in the clearing read's cycle survives: set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat <= hso_pkg::IRQ_RESET;
      irq     <= 1'b0;
    end else begin
      irqStat <= ((regRd && regAddr == hso_pkg::REG_IRQ_STAT) ? 3'h0 : irqStat) | irqEvt;
      irq     <= |(irqStat & irqMask);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 32'h0000_0000;
    end else if (regRd) begin
      unique case (regAddr)
        hso_pkg::REG_CTRL:     regRdData <= {30'h0, ctrl};
        hso_pkg::REG_STATUS:   regRdData <= {23'h0, wakeFromDevice, calStart, (txPhase != hso_pkg::TX_IDLE),
                                             comWakeDet, comInitDet, state};
        hso_pkg::REG_IRQ_STAT: regRdData <= {29'h0, irqStat};
        hso_pkg::REG_IRQ_MASK: regRdData <= {29'h0, irqMask};
        default:               regRdData <= 32'h0000_0000;
      endcase
    end else begin
      regRdData <= 32'h0000_0000;
    end
  end

  // checks
  logic [7:0] quietCnt;
  logic [3:0] sentBursts;

  always_ff @(posedge clk or negedge fsmRst_n) begin
    if (!fsmRst_n) begin
      quietCnt   <= 8'h00;
      sentBursts <= 4'h0;
    end else begin
      quietCnt <= txAlignBurst ? 8'h00 : ((quietCnt == 8'hFF) ? quietCnt : quietCnt + 8'h01);
      if (resetStart || wakeStart) begin
        sentBursts <= 4'h0;
      end else if (txAlignBurst && txCnt == 8'h00) begin
        sentBursts <= sentBursts + 4'h1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!fsmRst_n);

  sequence s_burst14;
    txAlignBurst [*8] ##1 txAlignBurst [*6] ##1 !txAlignBurst;
  endsequence
  property p_burstLen;
    $rose(txAlignBurst) |-> s_burst14;
  endproperty
  a_burstLen: assert property (p_burstLen) else $error("align burst length wrong");

  property p_wakeHold;
    txDone && txWake |-> quietCnt >= hso_pkg::WAKE_HOLD_CYC;
  endproperty
  a_wakeHold: assert property (p_wakeHold) else $error("idle after comwake too short");

  property p_burstCount;
    txDone |-> sentBursts == 4'h6 && !txAlignBurst;
  endproperty
  a_burstCount: assert property (p_burstCount) else $error("oob burst count not six");

  property p_wakeDrop;
    comWakeDet && rxIdle && idleCnt > hso_pkg::WAKE_OFF_MAX_CYC |=> !comWakeDet;
  endproperty
  a_wakeDrop: assert property (p_wakeDrop) else $error("wake detector held past off threshold");

  property p_initForce;
    comInitDet && state != hso_pkg::host_reset_state |=> state == hso_pkg::host_wait_init_release_state;
  endproperty
  a_initForce: assert property (p_initForce) else $error("cominit did not force release wait");

  property p_leaveReset;
    state == hso_pkg::host_reset_state |=> state != hso_pkg::host_reset_state ##1 $past(txAlignBurst);
  endproperty
  a_leaveReset: assert property (p_leaveReset) else $error("reset exit without comreset");

  property p_initHold;
    state == hso_pkg::host_wait_init_state && !comInitDet |=> state == hso_pkg::host_wait_init_state;
  endproperty
  a_initHold: assert property (p_initHold) else $error("left wait-init without cominit");

  sequence s_initReleased;
    state == hso_pkg::host_wait_init_release_state && !comInitDet;
  endsequence
  property p_toCal;
    s_initReleased |=> state == hso_pkg::host_calibration_state;
  endproperty
  a_toCal: assert property (p_toCal) else $error("no calibration after cominit release");

  property p_calBypass;
    // a comreset still running may legally delay the wake, so only an idle sender is held to it
    state == hso_pkg::host_calibration_state && !ctrl[hso_pkg::CTRL_CAL_EN] && !comInitDet &&
      txPhase == hso_pkg::TX_IDLE
      |=> state == hso_pkg::host_send_wake_state ##[1:4] txAlignBurst;
  endproperty
  a_calBypass: assert property (p_calBypass) else $error("bypassed calibration did not send wake");

  property p_wakeBranch;
    state == hso_pkg::host_send_wake_state && txDone && txWake && !comInitDet
      |=> state == ($past(comWakeDet) ? hso_pkg::host_wait_wake_release_state : hso_pkg::host_wait_wake_state);
  endproperty
  a_wakeBranch: assert property (p_wakeBranch) else $error("wrong state after comwake");

  sequence s_wakeSeen;
    state == hso_pkg::host_wait_wake_state && comWakeDet && !comInitDet;
  endsequence
  property p_wakeSeen;
    s_wakeSeen |=> state == hso_pkg::host_wait_wake_release_state;
  endproperty
  a_wakeSeen: assert property (p_wakeSeen) else $error("wake not followed by release wait");

  property p_toAlign;
    state == hso_pkg::host_wait_wake_release_state && !comWakeDet && !comInitDet
      |=> state == hso_pkg::host_wait_align_state && phyWaitAlign;
  endproperty
  a_toAlign: assert property (p_toAlign) else $error("no align wait after wake release");

endmodule : hso_oob_host

// file: sim/hso_dev_model.sv
module hso_dev_model (
  input  wire logic clk,
  input  wire logic sendInit,
  input  wire logic sendWake,
  output logic      rxIdle
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int burstLen = 14;
  localparam int initGap  = 40;
  localparam int wakeGap  = 14;
  // over the off threshold so the host sees release, under the crosstalk limit
  localparam int wakeTail = 25;

  // leading gap included, so the detector sees six spacings per signal when the line was driven before, five when it was already idle
  task automatic train(input int gap);
    for (int b = 0; b < 6; b++) begin
      rxIdle <= 1'b1;
      repeat (gap) @(posedge clk);
      rxIdle <= 1'b0;
      repeat (burstLen) @(posedge clk);
    end
    rxIdle <= 1'b1;
  endtask : train

  initial begin
    rxIdle = 1'b1;
    forever begin
      @(posedge clk);
      if (sendInit) begin
        train(initGap);
      end else if (sendWake) begin
        train(wakeGap);
        repeat (wakeTail) @(posedge clk);
        rxIdle <= 1'b0;
      end
    end
  end
endmodule : hso_dev_model

// file: sim/tb_serial_host_oob_powerup_fsm.sv
module tb_serial_host_oob_powerup_fsm;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk          = 1'b0;
  logic        rst_n        = 1'b0;
  logic        hostResetReq = 1'b0;
  logic        calDone      = 1'b0;
  logic [3:0]  regAddr      = 4'h0;
  logic [31:0] regWrData    = 32'h0;
  logic        regWr        = 1'b0;
  logic        regRd        = 1'b0;
  logic        sendInit     = 1'b0;
  logic        sendWake     = 1'b0;
  logic        rxIdle;
  logic [31:0] regRdData;
  logic        txAlignBurst;
  logic        calStart;
  logic        phyWaitAlign;
  logic        irq;
  int          n_fail       = 0;
  int          checks       = 0;
  int          cycles       = 0;
  logic [31:0] d;
  logic [3:0]  st;

  always #4 clk = ~clk;

  hso_oob_host dut (
    .clk          (clk),
    .rst_n        (rst_n),
    .hostResetReq (hostResetReq),
    .rxIdle       (rxIdle),
    .calDone      (calDone),
    .regAddr      (regAddr),
    .regWrData    (regWrData),
    .regWr        (regWr),
    .regRd        (regRd),
    .regRdData    (regRdData),
    .txAlignBurst (txAlignBurst),
    .calStart     (calStart),
    .phyWaitAlign (phyWaitAlign),
    .irq          (irq)
  );

  hso_dev_model partner (
    .clk      (clk),
    .sendInit (sendInit),
    .sendWake (sendWake),
    .rxIdle   (rxIdle)
  );

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic regWrite(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= v;
    regWr     <= 1'b1;
    @(posedge clk);
    regWr     <= 1'b0;
  endtask : regWrite

  task automatic regRead(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    #1;
    v = regRdData;
  endtask : regRead

  // bounded poll: returns the first state seen that differs from 'from'
  task automatic pollState(input logic [3:0] from, output logic [3:0] s);
    for (int i = 0; i < 400; i++) begin
      regRead(hso_pkg::REG_STATUS, d);
      s = d[3:0];
      if (s !== from) break;
    end
  endtask : pollState

  task automatic devCmd(input logic wake);
    @(posedge clk);
    if (wake) sendWake <= 1'b1;
    else sendInit <= 1'b1;
    @(posedge clk);
    sendWake <= 1'b0;
    sendInit <= 1'b0;
  endtask : devCmd

  task automatic measureTrain(input logic [7:0] gap);
    int n;
    for (int b = 0; b < 6; b++) begin
      n = 0;
      while (txAlignBurst !== 1'b1 && n < 1000) begin
        @(posedge clk);
        #1;
        n++;
      end
      if (b > 0) check(32'(n), 32'(gap));
      n = 0;
      while (txAlignBurst === 1'b1 && n < 100) begin
        @(posedge clk);
        #1;
        n++;
      end
      check(32'(n), 32'(hso_pkg::BURST_CYC));
    end
    n = 0;
    while (txAlignBurst !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(32'(n), 32'h3C);
  endtask : measureTrain

  task automatic testPowerUp();
    fork
      measureTrain(hso_pkg::INIT_GAP_CYC);
      begin
        regRead(hso_pkg::REG_CTRL, d);
        check(d, 32'h0);
        @(posedge clk);
        #1;
        check(regRdData, 32'h0);
        regRead(4'h2, d);
        check(d, 32'h0);
        regWrite(4'h3, 32'hFFFFFFFF);
        regRead(hso_pkg::REG_CTRL, d);
        check(d, 32'h0);
        regWrite(hso_pkg::REG_IRQ_MASK, 32'h4);
        regRead(hso_pkg::REG_IRQ_MASK, d);
        check(d, 32'h4);
        regRead(hso_pkg::REG_IRQ_STAT, d);
        check(d, 32'h0);
      end
    join
    regRead(hso_pkg::REG_STATUS, d);
    check({28'h0, d[3:0]}, 32'h1);
    $display("power-up test done");
  endtask : testPowerUp

  task automatic testLinkUp();
    devCmd(1'b0);
    fork
      measureTrain(hso_pkg::WAKE_GAP_CYC);
      begin
        pollState(4'h1, st);
        check(32'(st), 32'h2);
        check(32'(irq), 32'h0);
        pollState(4'h2, st);
        if (st === 4'h3) pollState(4'h3, st);
        check(32'(st), 32'h4);
      end
    join
    pollState(4'h4, st);
    check(32'(st), 32'h5);
    devCmd(1'b1);
    pollState(4'h5, st);
    check(32'(st), 32'h6);
    pollState(4'h6, st);
    check(32'(st), 32'h7);
    check(32'(phyWaitAlign), 32'h1);
    check(32'(irq), 32'h1);
    regRead(hso_pkg::REG_IRQ_STAT, d);
    check(d, 32'h7);
    regRead(hso_pkg::REG_IRQ_STAT, d);
    check(d, 32'h0);
    @(posedge clk);
    #1;
    check(32'(irq), 32'h0);
    $display("link-up test done");
  endtask : testLinkUp

  task automatic testPowerDown();
    regWrite(hso_pkg::REG_CTRL, 32'h2);
    pollState(4'h7, st);
    check(32'(st), 32'h8);
    regWrite(hso_pkg::REG_CTRL, 32'h0);
    fork
      measureTrain(hso_pkg::WAKE_GAP_CYC);
      begin
        pollState(4'h8, st);
        check(32'(st), 32'h4);
        check(32'(d[8]), 32'h0);
      end
    join
    pollState(4'h4, st);
    check(32'(st), 32'h5);
    $display("power-down test done");
  endtask : testPowerDown

  task automatic testCalibrate();
    regWrite(hso_pkg::REG_CTRL, 32'h1);
    devCmd(1'b0);
    pollState(4'h5, st);
    check(32'(st), 32'h2);
    pollState(4'h2, st);
    check(32'(st), 32'h3);
    check(32'(calStart), 32'h1);
    repeat (20) @(posedge clk);
    regRead(hso_pkg::REG_STATUS, d);
    check({28'h0, d[3:0]}, 32'h3);
    @(posedge clk);
    calDone <= 1'b1;
    pollState(4'h3, st);
    check(32'(st), 32'h4);
    @(posedge clk);
    calDone <= 1'b0;
    // device wake overlaps the end of the host wake
    repeat (40) @(posedge clk);
    devCmd(1'b1);
    pollState(4'h4, st);
    check(32'(st), 32'h6);
    pollState(4'h6, st);
    check(32'(st), 32'h7);
    // device-originated wake out of power down
    regWrite(hso_pkg::REG_CTRL, 32'h2);
    pollState(4'h7, st);
    check(32'(st), 32'h8);
    devCmd(1'b1);
    pollState(4'h8, st);
    check(32'(st), 32'h6);
    // drop the request before release, else align goes straight back down
    regWrite(hso_pkg::REG_CTRL, 32'h0);
    pollState(4'h6, st);
    check(32'(st), 32'h7);
    check(32'(d[8]), 32'h1);
    $display("calibration test done");
  endtask : testCalibrate

  task automatic testHostReset();
    @(posedge clk);
    hostResetReq <= 1'b1;
    regRead(hso_pkg::REG_STATUS, d);
    check({28'h0, d[3:0]}, 32'h0);
    // registered output, so it clears one edge after the state
    check(32'(phyWaitAlign), 32'h0);
    @(posedge clk);
    hostResetReq <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    check(32'(txAlignBurst), 32'h1);
    @(posedge clk);
    hostResetReq <= 1'b1;
    #1;
    check(32'(txAlignBurst), 32'h0);
    @(posedge clk);
    hostResetReq <= 1'b0;
    measureTrain(hso_pkg::INIT_GAP_CYC);
    regRead(hso_pkg::REG_STATUS, d);
    check({28'h0, d[3:0]}, 32'h1);
    $display("host reset test done");
  endtask : testHostReset

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      $display("ERROR %0t: run did not finish", $time);
      summarize();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    testPowerUp();
    testLinkUp();
    testPowerDown();
    testCalibrate();
    testHostReset();
    summarize();
  end
endmodule : tb_serial_host_oob_powerup_fsm
